/* File: rtl/tmc_timer.v */
// Timer 2 core: capture with auto-zero, duty capture and split 8-bit modes.
// Assumes count ticks and trigger sources come from outside; ticks are
// single-cycle pulses on mclk, triggers are raw pins and get synchronised.
`timescale 1ns/10ps
`include "tmc_timer_regs.vh"
module tmc_timer #(
  parameter NSRC = `TMC_SRC_NUM
) (
  input  wire            mclk,
  input  wire            srst,
  // Trigger sources and selection
  input  wire [NSRC-1:0] triggerSources,
  input  wire [2:0]      triggerSelect,
  // Count ticks
  input  wire            highTick,
  input  wire [3:0]      lowTicks,
  input  wire [1:0]      lowClockSel,
  // Mode and control levels
  input  wire            splitSelect,
  input  wire            modeSelectHigh,
  input  wire            modeSelectLow,
  input  wire            captureReloadSelect,
  input  wire            controlBankSelect,
  input  wire            fallingEdgeEnable,
  input  wire            risingEdgeEnable,
  input  wire            overflowInterruptIgnore,
  input  wire            lowRunAutoClear,
  input  wire            bankBit5In,
  input  wire            bankBit4In,
  input  wire            bankBit6In,
  // Software run strobes
  input  wire            runSetPulse,
  input  wire            runClrPulse,
  input  wire            lowRunSetPulse,
  input  wire            lowRunClrPulse,
  // Software writes
  input  wire            countWrite,
  input  wire [15:0]     countWdata,
  input  wire            captureWrite,
  input  wire [15:0]     captureWdata,
  // Software flag clears
  input  wire            overflowFlagClr,
  input  wire            externalFlagClr,
  input  wire            lowOverflowFlagClr,
  // Counter and capture bytes
  output reg  [7:0]      countLowByte,
  output reg  [7:0]      countHighByte,
  output reg  [7:0]      captureReloadLow,
  output reg  [7:0]      captureReloadHigh,
  // Run bits, flags and mapped control bits
  output reg             mainRunBit,
  output reg             lowRunBit,
  output reg             overflowFlag,
  output reg             externalFlag,
  output reg             lowOverflowFlag,
  output reg             receiveClockSelect,
  output reg             transmitClockSelect,
  output reg             lowClockScaling,
  output reg             lowOverflowIntEnable,
  output reg             triggerPolarityInvert,
  // Events
  output reg             overflowEventOut,
  output wire            timerIrq
);

  // One-hot duty capture states
  localparam ST_IDLE  = 4'b0001;
  localparam ST_WAIT1 = 4'b0010;
  localparam ST_WAIT2 = 4'b0100;
  localparam ST_WAIT3 = 4'b1000;

  reg         trigSync1_reg;
  reg         trigSync2_reg;
  reg         trigPrev_reg;
  reg  [3:0]  dutyState_reg;
  reg  [3:0]  dutyState_next;
  wire        trigRaw;
  wire        trigLevel;
  wire        riseEdge;
  wire        fallEdge;
  wire        anyEdge;
  wire        enabledEdge;
  wire        dutyMode;
  wire        captureMode;
  wire        autoZero;
  wire        splitAutoZero;
  wire        reloadMode;
  wire        reloadTrig;
  wire        lowTick;
  wire        inWait1;
  wire        inWait2;
  wire        inWait3;
  wire        dutyCounting;
  wire        highRun;
  wire        highOvf;
  wire        lowOvf;
  wire        fullOvf;
  wire        dutyFirst;
  wire        dutySecond;
  wire        dutyThird;
  wire        ovfFlagSet;
  wire        lowFlagClr;
  wire        irqOvf;
  wire        irqLow;
  wire        overflowEvent_next;
  wire [15:0] countWord;

  // Select one source, then synchronise with two flops
  assign trigRaw = triggerSources[triggerSelect] ^ triggerPolarityInvert;
  always @(posedge mclk) begin
    trigSync1_reg <= trigRaw;
    trigSync2_reg <= trigSync1_reg;
  end
  // Only the second flop stage feeds the edge detector
  assign trigLevel = trigSync2_reg;
  // Follows the level through reset, so a high pin gives no false edge
  always @(posedge mclk) begin
    trigPrev_reg <= trigLevel;
  end
  assign riseEdge    = trigLevel & ~trigPrev_reg;
  assign fallEdge    = ~trigLevel & trigPrev_reg;
  assign anyEdge     = riseEdge | fallEdge;
  assign enabledEdge = (fallEdge & fallingEdgeEnable) | (riseEdge & risingEdgeEnable);

  // Mode decode
  assign dutyMode = ~splitSelect & modeSelectHigh & captureReloadSelect & ~modeSelectLow;
  assign captureMode   = captureReloadSelect & ~modeSelectHigh;
  assign autoZero      = captureMode & modeSelectLow & ~splitSelect;
  assign splitAutoZero = splitSelect & ~modeSelectHigh & captureReloadSelect & modeSelectLow;
  // Only the reload-with-trigger mode reloads on a trigger edge
  assign reloadMode    = ~captureReloadSelect & ~modeSelectHigh & modeSelectLow;
  assign reloadTrig    = reloadMode & enabledEdge;

  assign lowTick   = lowTicks[lowClockSel];
  assign countWord = {countHighByte, countLowByte};
  // Duty capture progress
  assign inWait1    = (dutyState_reg == ST_WAIT1);
  assign inWait2    = (dutyState_reg == ST_WAIT2);
  assign inWait3    = (dutyState_reg == ST_WAIT3);
  assign dutyFirst  = dutyMode & inWait1 & riseEdge;
  assign dutySecond = dutyMode & inWait2 & anyEdge;
  assign dutyThird  = dutyMode & inWait3 & anyEdge;
  // Count is idle until the first edge and freezes on the third
  assign dutyCounting = (inWait2 | inWait3) & ~dutyThird;
  assign highRun = mainRunBit & highTick & (~dutyMode | dutyCounting);
  assign fullOvf = ~splitSelect & highRun & (countWord == `TMC_FULL_WORD);
  assign highOvf = splitSelect & highRun & (countHighByte == `TMC_FULL_BYTE);
  assign lowOvf  = splitSelect & lowRunBit & lowTick & (countLowByte == `TMC_FULL_BYTE);

  // Flag conditions and interrupt sources
  assign ovfFlagSet = highOvf | (fullOvf & ~receiveClockSelect & ~transmitClockSelect);
  assign lowFlagClr = lowOverflowFlagClr | (~controlBankSelect & bankBit5In);
  assign irqOvf     = overflowFlag & ~overflowInterruptIgnore;
  assign irqLow     = splitSelect & lowOverflowFlag & lowOverflowIntEnable;
  assign overflowEvent_next = splitSelect ? lowOvf : fullOvf;

  always @* begin
    dutyState_next = dutyState_reg;
    case (dutyState_reg)
      ST_IDLE: begin
        if (dutyMode & mainRunBit) begin
          dutyState_next = ST_WAIT1;
        end
      end
      ST_WAIT1: begin
        if (~dutyMode | ~mainRunBit) begin
          dutyState_next = ST_IDLE;
        end else if (dutyFirst) begin
          dutyState_next = ST_WAIT2;
        end
      end
      ST_WAIT2: begin
        if (~dutyMode | ~mainRunBit) begin
          dutyState_next = ST_IDLE;
        end else if (dutySecond) begin
          dutyState_next = ST_WAIT3;
        end
      end
      ST_WAIT3: begin
        if (~dutyMode | ~mainRunBit | dutyThird) begin
          dutyState_next = ST_IDLE;
        end
      end
      default: begin
        dutyState_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      dutyState_reg <= ST_IDLE;
    end else begin
      dutyState_reg <= dutyState_next;
    end
  end

  // Main run: the hardware clear on the third duty edge wins over a set
  always @(posedge mclk) begin
    if (srst) begin
      mainRunBit <= 1'b0;
    end else if (dutyThird) begin
      mainRunBit <= 1'b0;
    end else if (runSetPulse) begin
      mainRunBit <= 1'b1;
    end else if (runClrPulse) begin
      mainRunBit <= 1'b0;
    end
  end

  // Low run: the auto-clear on a high-byte wrap wins over a set
  always @(posedge mclk) begin
    if (srst) begin
      lowRunBit <= 1'b0;
    end else if (highOvf & lowRunAutoClear) begin
      lowRunBit <= 1'b0;
    end else if (lowRunSetPulse) begin
      lowRunBit <= 1'b1;
    end else if (lowRunClrPulse) begin
      lowRunBit <= 1'b0;
    end
  end

  // Counter bytes
  always @(posedge mclk) begin
    if (srst) begin
      countHighByte <= `TMC_ZERO_BYTE;
      countLowByte  <= `TMC_ZERO_BYTE;
    end else if (countWrite) begin
      {countHighByte, countLowByte} <= countWdata;
    end else if (splitSelect) begin
      // Two independent byte counters
      if (splitAutoZero & enabledEdge) begin
        countHighByte <= `TMC_ZERO_BYTE;
      end else if (highOvf | (reloadTrig & ~modeSelectHigh)) begin
        countHighByte <= captureReloadHigh;
      end else if (highRun) begin
        countHighByte <= countHighByte + 8'h01;
      end
      if (lowOvf) begin
        countLowByte <= captureReloadLow;
      end else if (lowRunBit & lowTick) begin
        countLowByte <= countLowByte + 8'h01;
      end
    end else if (dutyFirst) begin
      {countHighByte, countLowByte} <= `TMC_COUNT_RST;
    end else if (autoZero & enabledEdge) begin
      {countHighByte, countLowByte} <= `TMC_COUNT_RST;
    end else if (fullOvf & ~captureReloadSelect) begin
      {countHighByte, countLowByte} <= {captureReloadHigh, captureReloadLow};
    end else if (reloadTrig) begin
      {countHighByte, countLowByte} <= {captureReloadHigh, captureReloadLow};
    end else if (highRun) begin
      {countHighByte, countLowByte} <= countWord + 16'h0001;
    end
  end

  // Capture pair
  always @(posedge mclk) begin
    if (srst) begin
      captureReloadHigh <= `TMC_ZERO_BYTE;
      captureReloadLow  <= `TMC_ZERO_BYTE;
    end else if (captureWrite) begin
      {captureReloadHigh, captureReloadLow} <= captureWdata;
    end else if (dutySecond) begin
      {captureReloadHigh, captureReloadLow} <= countWord;
    end else if (splitSelect & captureMode & enabledEdge) begin
      captureReloadHigh <= countHighByte;
    end else if (~splitSelect & captureMode & enabledEdge) begin
      {captureReloadHigh, captureReloadLow} <= countWord;
    end
  end

  // Flags: a hardware set in the same cycle as a clear wins
  always @(posedge mclk) begin
    if (srst) begin
      overflowFlag    <= 1'b0;
      externalFlag    <= 1'b0;
      lowOverflowFlag <= 1'b0;
    end else begin
      if (ovfFlagSet) begin
        overflowFlag <= 1'b1;
      end else if (overflowFlagClr) begin
        overflowFlag <= 1'b0;
      end
      if (dutyMode) begin
        if ((dutySecond & fallEdge & fallingEdgeEnable)
            | (dutyThird & enabledEdge)) begin
          externalFlag <= 1'b1;
        end else if (externalFlagClr) begin
          externalFlag <= 1'b0;
        end
      end else if (enabledEdge) begin
        externalFlag <= 1'b1;
      end else if (externalFlagClr) begin
        externalFlag <= 1'b0;
      end
      if (lowOvf) begin
        lowOverflowFlag <= 1'b1;
      end else if (lowFlagClr) begin
        lowOverflowFlag <= 1'b0;
      end
    end
  end

  // Shared control bits routed by the bank select
  always @(posedge mclk) begin
    if (srst) begin
      lowOverflowIntEnable  <= 1'b0;
      triggerPolarityInvert <= 1'b0;
    end else if (controlBankSelect) begin
      lowOverflowIntEnable  <= bankBit4In;
      triggerPolarityInvert <= bankBit6In;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      receiveClockSelect    <= 1'b0;
      transmitClockSelect   <= 1'b0;
      lowClockScaling       <= 1'b0;
    end else if (~controlBankSelect) begin
      receiveClockSelect    <= bankBit5In;
      transmitClockSelect   <= bankBit4In;
      lowClockScaling       <= bankBit6In;
    end
  end

  // Exported overflow pulse, one cycle after the wrap
  always @(posedge mclk) begin
    if (srst) begin
      overflowEventOut <= 1'b0;
    end else begin
      overflowEventOut <= overflowEvent_next;
    end
  end

  // Shared interrupt request
  assign timerIrq = irqOvf | externalFlag | irqLow;

endmodule // tmc_timer

/* File: rtl/tmc_timer_regs.vh */
// Constants for the capture/split timer block.
// Assumes a single system clock; trigger sources arrive asynchronously.
`ifndef TMC_TIMER_REGS_VH
`define TMC_TIMER_REGS_VH
`define TMC_COUNT_RST   16'h0000
`define TMC_ZERO_BYTE   8'h00
`define TMC_FULL_BYTE   8'hFF
`define TMC_FULL_WORD   16'hFFFF
`define TMC_LOWDIV_TC   4'hB
`define TMC_SRC_NUM     8
`endif

/* File: verification/testbench.sv */
// Self-checking bench: auto-zero capture, duty capture, split counters, bank mapping.
// Assumes the trigger model feeds the source pins; one 40 MHz clock.
`timescale 1ns/10ps
module testbench;
  reg         mclk = 0, srst = 1, trig = 0, highTick = 0, splitSelect = 0, modeSelectHigh = 0;
  reg         modeSelectLow = 0, captureReloadSelect = 0, controlBankSelect = 0, bankBit5In = 0;
  reg         fallingEdgeEnable = 0, risingEdgeEnable = 0, overflowInterruptIgnore = 0;
  reg         lowRunAutoClear = 0, bankBit4In = 0, bankBit6In = 0, runSetPulse = 0;
  reg         runClrPulse = 0, lowRunSetPulse = 0, lowRunClrPulse = 0, countWrite = 0;
  reg         captureWrite = 0, overflowFlagClr = 0, externalFlagClr = 0, lowOverflowFlagClr = 0;
  reg  [2:0]  triggerSelect = 3'h5;
  reg  [3:0]  lowTicks = 4'h0;
  reg  [1:0]  lowClockSel = 2'h0;
  reg  [15:0] countWdata = 16'h0000, captureWdata = 16'h0000, v, hi, lo;
  reg  [31:0] seed = 32'hD429C7DC;
  wire [7:0]  triggerSources, countLowByte, countHighByte, captureReloadLow, captureReloadHigh;
  wire        mainRunBit, lowRunBit, overflowFlag, externalFlag, lowOverflowFlag, timerIrq;
  wire        receiveClockSelect, transmitClockSelect, lowClockScaling, lowOverflowIntEnable;
  wire        triggerPolarityInvert, overflowEventOut;
  integer     errors = 0, checked = 0, i, n;

  always #12.5 mclk = ~mclk;
  tmc_timer i_tmc_timer (.*);
  tmc_trig_model i_tmc_trig_model (.mclk(mclk), .sel(triggerSelect), .level(trig),
                                   .pins(triggerSources));

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function expIrq(input ovf, ign, lowf, lowEn, ext);
    expIrq = ext | (ovf & ~ign) | (lowf & lowEn);
  endfunction
  task chk(input [15:0] got, exp);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task setMode(input [3:0] m);
    tick(1);
    {splitSelect, modeSelectHigh, captureReloadSelect, modeSelectLow} <= m;
  endtask
  task wr(input [15:0] c, p);
    {countWrite, captureWrite, countWdata, captureWdata} <= {2'h3, c, p};
    tick(1);
    {countWrite, captureWrite} <= 2'h0;
    tick(1);
  endtask
  task runPulse(input [2:0] m);
    {runSetPulse, lowRunSetPulse, runClrPulse} <= m;
    tick(1);
    {runSetPulse, lowRunSetPulse, runClrPulse} <= 3'h0;
    tick(1);
  endtask
  task clrFlags(input [2:0] m);
    {overflowFlagClr, externalFlagClr, lowOverflowFlagClr} <= m;
    tick(1);
    {overflowFlagClr, externalFlagClr, lowOverflowFlagClr} <= 3'h0;
    tick(1);
  endtask
  task waitUntil(input integer k);
    n = 0;
    while ((k == 0 ? externalFlag : k == 1 ? overflowFlag : ~mainRunBit) !== 1'b1 && n < 100) begin
      tick(1);
      n = n + 1;
    end
    chk(n < 100, 16'h0001);
  endtask
  task stop_test;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    errors = errors + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test;
  end

  initial begin
    tick(16);
    srst <= 0;
    for (i = 0; i < 6; i = i + 1) begin
      setMode(i > 3 ? 4'hA : i[1] ? 4'hB : 4'h3);
      {fallingEdgeEnable, risingEdgeEnable, highTick, trig} <= {3'h0, ~i[0]};
      tick(8);
      clrFlags(3'h7);
      seed = xs(seed);
      v = seed[15:0];
      wr(v, 16'h0000);
      {fallingEdgeEnable, risingEdgeEnable, trig} <= {~i[0], i[0], i[0]};
      waitUntil(0);
      chk(captureReloadHigh, v[15:8]);
      chk(countHighByte, i > 3 ? v[15:8] : 16'h0000);
      if (i < 2) chk({captureReloadLow, countLowByte}, {v[7:0], 8'h00});
      $display("auto-zero test %0d done", i);
    end
    setMode(4'h6);
    {fallingEdgeEnable, risingEdgeEnable, highTick, trig} <= 4'h6;
    clrFlags(3'h7);
    wr(16'h0000, 16'h0000);
    runPulse(3'h4);
    seed = xs(seed);
    hi = 16'h0008 + seed[4:0];
    lo = 16'h0008 + seed[12:8];
    tick(10);
    chk({countHighByte, countLowByte}, 16'h0000);
    trig <= 1;
    tick(hi);
    chk(externalFlag, 16'h0000);
    trig <= 0;
    tick(lo);
    chk(externalFlag, 16'h0000);
    trig <= 1;
    waitUntil(2);
    tick(1);
    chk(externalFlag, 16'h0001);
    chk({captureReloadHigh, captureReloadLow}, hi - 16'h0001);
    chk({countHighByte, countLowByte}, hi + lo - 16'h0001);
    $display("duty capture test done");
    setMode(4'h8);
    {controlBankSelect, bankBit4In, bankBit5In, bankBit6In} <= 4'hC;
    {highTick, lowTicks, overflowInterruptIgnore, lowRunAutoClear} <= 7'h7F;
    clrFlags(3'h7);
    seed = xs(seed);
    lowClockSel <= seed[1:0];
    wr(16'hF0FC, seed[31:16]);
    runPulse(3'h6);
    waitUntil(1);
    tick(2);
    chk(lowRunBit, 16'h0000);
    chk(lowOverflowFlag, 16'h0001);
    chk(timerIrq, expIrq(1, 1, 1, 1, 0));
    clrFlags(3'h1);
    chk(timerIrq, expIrq(1, 1, 0, 1, 0));
    chk(overflowFlag, 16'h0001);
    overflowInterruptIgnore <= 0;
    tick(2);
    chk(timerIrq, expIrq(1, 0, 0, 1, 0));
    $display("split test done");
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      {controlBankSelect, bankBit4In, bankBit5In, bankBit6In} <= {i[0], seed[2:0]};
      tick(2);
      if (i[0]) chk({lowOverflowIntEnable, triggerPolarityInvert}, {seed[2], seed[0]});
      else chk({receiveClockSelect, transmitClockSelect, lowClockScaling}, {seed[1], seed[2], seed[0]});
    end
    $display("bank mapping test done");
    stop_test;
  end
endmodule // testbench

/* File: verification/tmc_timer_props.sv */
// Concurrent checks on the timer core ports, bound into every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tmc_timer_props (
  input wire       mclk, srst, splitSelect, modeSelectHigh, modeSelectLow, captureReloadSelect,
  input wire       controlBankSelect, countWrite, lowRunAutoClear, overflowInterruptIgnore,
  input wire       externalFlagClr, bankBit4In, bankBit5In, bankBit6In, mainRunBit, lowRunBit,
  input wire       overflowFlag, externalFlag, lowOverflowFlag, receiveClockSelect,
  input wire       transmitClockSelect, lowClockScaling, lowOverflowIntEnable,
  input wire       triggerPolarityInvert, overflowEventOut, timerIrq,
  input wire [7:0] countLowByte, countHighByte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire [15:0] cnt = {countHighByte, countLowByte};
  wire [3:0]  md  = {splitSelect, modeSelectHigh, captureReloadSelect, modeSelectLow};

  a_zero_count: assert property (md == 4'h3 && $rose(externalFlag) && !$past(countWrite)
    |-> cnt == 16'h0000) else $error("count not zeroed by capture");
  a_zero_high: assert property (md == 4'hB && $rose(externalFlag) && !$past(countWrite)
    |-> countHighByte == 8'h00) else $error("high byte not zeroed by capture");
  a_duty_freeze: assert property (md == 4'h6 && $past(md) == 4'h6 && !$past(mainRunBit)
    && !$past(countWrite) && !$past(srst) |-> $stable(cnt)) else $error("stopped count moved");
  a_high_hold: assert property (md == 4'h8 && $past(md) == 4'h8 && !$past(mainRunBit)
    && !$past(countWrite) && !$past(srst) |-> $stable(countHighByte))
    else $error("high byte moved without run");
  a_auto_clear: assert property (splitSelect && lowRunAutoClear && $rose(overflowFlag)
    |-> !lowRunBit) else $error("low run kept after high wrap");
  a_irq_split: assert property (splitSelect |-> timerIrq == (externalFlag
    || (overflowFlag && !overflowInterruptIgnore) || (lowOverflowFlag && lowOverflowIntEnable)))
    else $error("interrupt request wrong");
  a_ext_sticky: assert property (splitSelect && externalFlag && !externalFlagClr
    |=> externalFlag) else $error("external flag dropped by hardware");
  a_low_event: assert property (splitSelect && $past(splitSelect) && overflowEventOut
    |-> lowOverflowFlag || $past(lowOverflowFlag)) else $error("event without low wrap");
  a_bank_one: assert property (controlBankSelect |=> lowOverflowIntEnable == $past(bankBit4In)
    && triggerPolarityInvert == $past(bankBit6In)) else $error("bank one mapping wrong");
  a_bank_zero: assert property (!controlBankSelect |=> receiveClockSelect == $past(bankBit5In)
    && transmitClockSelect == $past(bankBit4In) && lowClockScaling == $past(bankBit6In))
    else $error("bank zero mapping wrong");

  c_duty_stop: cover property (md == 4'h6 && $fell(mainRunBit));
  c_low_event: cover property (splitSelect && overflowEventOut);
  c_zero_cap: cover property (md == 4'h3 && $rose(externalFlag));
endmodule // tmc_timer_props

bind tmc_timer tmc_timer_props i_tmc_timer_props (.*);

/* File: verification/tmc_trig_model.sv */
// Trigger source model: drives the eight trigger pins of the timer core.
// Assumes the bench gives the wanted level of the selected pin.
`timescale 1ns/10ps
module tmc_trig_model (
  input  wire       mclk,
  input  wire [2:0] sel,
  input  wire       level,
  output reg  [7:0] pins
);
  reg [31:0] nz = 32'h5A3C96E1;
  // Unselected pins carry noise so a wrong source choice shows up
  always @(posedge mclk) begin
    nz <= {nz[30:0], nz[31] ^ nz[21] ^ nz[1] ^ nz[0]};
    pins <= (nz[7:0] & ~(8'h01 << sel)) | ({7'h00, level} << sel);
  end
endmodule // tmc_trig_model
